// >>> inc/rtcsa_consts.vh
// Purpose : Shared constants of the serial clock slave
// Assumes : Included by bare name from every design file
// Notes   : Definitions only
`ifndef RTCSA_CONSTS_VH
`define RTCSA_CONSTS_VH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define RTCSA_SLAVE_ADDR   7'h68
`define RTCSA_BYTE_BITS    4'h8
`define RTCSA_LAST_CLOCK   3'h6
`define RTCSA_NUM_LOCS     8

// ----------------------------------------------------------------------
// Location indices
// ----------------------------------------------------------------------
`define RTCSA_LOC_SEC      3'h0
`define RTCSA_LOC_MIN      3'h1
`define RTCSA_LOC_HOUR     3'h2
`define RTCSA_LOC_DAY      3'h3
`define RTCSA_LOC_DATE     3'h4
`define RTCSA_LOC_MONTH    3'h5
`define RTCSA_LOC_YEAR     3'h6
`define RTCSA_LOC_CAL      3'h7

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RTCSA_STOP_BIT     7
`define RTCSA_CENT_EN_BIT  7
`define RTCSA_CENT_BIT     6
`define RTCSA_RST_ZERO     8'h00
`define RTCSA_RST_ONE      8'h01

// ----------------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------------
`define RTCSA_OSC_HZ       32768
`define RTCSA_TICK_S       1
`define RTCSA_DIV_COUNT    (`RTCSA_OSC_HZ * `RTCSA_TICK_S)
`define RTCSA_DIV_W        16

`endif

// >>> design/rtcsa_buf2.v
// Purpose : Two-entry valid/ready buffer for received write bytes
// Assumes : Same clock on both sides
// Notes   : Full and empty are exact; ready drops when both slots hold
`timescale 1ns/10ps
`include "rtcsa_consts.vh"

module rtcsa_buf2 #(
  parameter W  = 11,
  parameter AW = 1
) (
  input  wire         sys_clk_in,
  input  wire         rstn_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);

  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0]   cnt;

  wire do_in  = in_valid_in & in_ready_out;
  wire do_out = out_valid_out & out_ready_in;

  assign in_ready_out  = (cnt != {1'b1, {AW{1'b0}}});
  assign out_valid_out = (cnt != {(AW+1){1'b0}});
  assign out_data_out  = mem[rp];

  // ----------------------------------------------------------------------
  // Pointers and storage
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (do_in) begin
        mem[wp] <= in_data_in;
        wp      <= wp + 1'b1;
      end
      if (do_out)
        rp <= rp + 1'b1;
      if (do_in && !do_out)
        cnt <= cnt + 1'b1;
      else if (do_out && !do_in)
        cnt <= cnt - 1'b1;
    end
  end

endmodule

// >>> design/rtcsa_timekeep.v
// Purpose : Internal BCD clock/calendar counters and one-second divider
// Assumes : osc_clk_in is the crystal timebase pin, asynchronous
// Notes   : Write port stalls in the cycle a second tick lands
`timescale 1ns/10ps
`include "rtcsa_consts.vh"

module rtcsa_timekeep #(
  parameter [`RTCSA_DIV_W-1:0] DIV_COUNT = `RTCSA_DIV_COUNT
) (
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire        osc_clk_in,
  input  wire        wr_valid_in,
  output wire        wr_ready_out,
  input  wire [2:0]  wr_addr_in,
  input  wire [7:0]  wr_data_in,
  output wire [63:0] time_out
);

  localparam [`RTCSA_DIV_W-1:0] DIV_LAST = DIV_COUNT - 16'h0001;

  // Adds one in BCD; carry out and wrap to lo past hi
  function [8:0] binc;
    input [7:0] v;
    input [7:0] hi;
    input [7:0] lo;
    begin
      if (v >= hi)
        binc = {1'b1, lo};
      else if (v[3:0] == 4'h9)
        binc = {1'b0, v + 8'h07};
      else
        binc = {1'b0, v + 8'h01};
    end
  endfunction

  // Last date of a month; every fourth year leaps, good up to 2100
  function [7:0] month_end;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      case (mon)
        8'h02:   month_end = leap ? 8'h29 : 8'h28;
        8'h04,
        8'h06,
        8'h09,
        8'h11:   month_end = 8'h30;
        default: month_end = 8'h31;
      endcase
    end
  endfunction

  reg [7:0] r [0:`RTCSA_NUM_LOCS-1];
  reg [`RTCSA_DIV_W-1:0] div;
  reg osc_m;
  reg osc_s;
  reg osc_d;
  integer k;

  wire osc_edge = osc_s & ~osc_d;
  wire tick     = osc_edge & (div == DIV_LAST) &
                  ~r[`RTCSA_LOC_SEC][`RTCSA_STOP_BIT];
  wire wr_go    = wr_valid_in & wr_ready_out;

  wire [8:0] n_sec  = binc({1'b0, r[0][6:0]}, 8'h59, 8'h00);
  wire [8:0] n_min  = binc({1'b0, r[1][6:0]}, 8'h59, 8'h00);
  wire [8:0] n_hour = binc({2'b00, r[2][5:0]}, 8'h23, 8'h00);
  wire [8:0] n_day  = binc(r[3], 8'h07, 8'h01);
  wire [8:0] n_date = binc(r[4], month_end(r[5], r[6]), 8'h01);
  wire [8:0] n_mon  = binc(r[5], 8'h12, 8'h01);
  wire [8:0] n_year = binc(r[6], 8'h99, 8'h00);

  assign wr_ready_out = ~tick;

  genvar g;
  generate
    for (g = 0; g < `RTCSA_NUM_LOCS; g = g + 1) begin : g_flat
      assign time_out[g*8 +: 8] = r[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    osc_m <= osc_clk_in;
    osc_s <= osc_m;
    if (!rstn_in) begin
      osc_d <= 1'b0;
      div   <= {`RTCSA_DIV_W{1'b0}};
      for (k = 0; k < `RTCSA_NUM_LOCS; k = k + 1)
        r[k] <= `RTCSA_RST_ZERO;
      r[`RTCSA_LOC_DAY]   <= `RTCSA_RST_ONE;
      r[`RTCSA_LOC_DATE]  <= `RTCSA_RST_ONE;
      r[`RTCSA_LOC_MONTH] <= `RTCSA_RST_ONE;
    end else begin
      osc_d <= osc_s;
      if (wr_go) begin
        r[wr_addr_in] <= wr_data_in;
        if (wr_addr_in <= `RTCSA_LAST_CLOCK)
          div <= {`RTCSA_DIV_W{1'b0}};
        else if (osc_edge)
          div <= div + 1'b1;
      end else if (tick) begin
        div     <= {`RTCSA_DIV_W{1'b0}};
        r[0]    <= {r[0][7], n_sec[6:0]};
        if (n_sec[8]) begin
          r[1] <= {r[1][7], n_min[6:0]};
          if (n_min[8]) begin
            r[2] <= {r[2][7:6], n_hour[5:0]};
            if (n_hour[8]) begin
              r[3] <= n_day[7:0];
              r[4] <= n_date[7:0];
              if (n_date[8]) begin
                r[5] <= n_mon[7:0];
                if (n_mon[8]) begin
                  r[6] <= n_year[7:0];
                  if (n_year[8] && r[2][`RTCSA_CENT_EN_BIT])
                    r[2][`RTCSA_CENT_BIT] <= ~r[2][`RTCSA_CENT_BIT];
                end
              end
            end
          end
        end
      end else if (osc_edge) begin
        div <= div + 1'b1;
      end
    end
  end

endmodule

// >>> design/rtcsa_slave.v
// Purpose : Two-wire slave access to an eight-location BCD real-time clock
// Assumes : scl_in, sda_in, osc_clk_in and the power-fail level are pins
// Notes   : No clock stretching; a full write buffer answers with no ack
//
// Overview of operation
// - Answer only transfers opening with start then slave address byte D0h or D1h.
// - Eight locations: seconds, minutes, hours, day, date, month, year, cal.
// - Address pointer steps by one after each data byte read or written.
// - Power fail aborts any transfer and clears the address pointer.
// - Bus ignored while supply is low; accepted again once it recovers.
// - SDA falling while SCL high is a start condition.
// - SDA rising while SCL high is a stop condition.
// - SDA stable while SCL high; changes only while SCL low.
// - Bytes are eight bits, MSB first, then a ninth acknowledge bit.
// - Any number of data bytes between start and stop.
// - Acknowledger holds SDA low through the whole ack clock high.
// - Addressed receiver acknowledges every byte it takes in.
// - After master's no-ack the transmitter releases SDA high.
// - Time and date held in packed BCD, hours in 24-hour form.
// - Months end after 28, 29, 30 or 31 days; leap years to 2100.
// - One-second tick comes from the 32.768 kHz crystal timebase.
// - Pointer advances only on the ack clock after each data byte.
// - User copy frozen while pointer is 00h-06h; resumes on stop or 07h.
// - In a write, first byte loads the pointer; later bytes store.
// - Completing a write to a clock location resets the divider chain.
`timescale 1ns/10ps
`include "rtcsa_consts.vh"

module rtcsa_slave #(
  parameter [`RTCSA_DIV_W-1:0] DIV_COUNT = `RTCSA_DIV_COUNT
) (
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  input  wire        osc_clk_in,
  input  wire        below_power_fail_threshold_in,
  output wire        busy_out,
  output wire [63:0] time_out
);

  // ----------------------------------------------------------------------
  // States and byte kinds
  // ----------------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_RX     = 3'h1;
  localparam [2:0] S_RX_ACK = 3'h2;
  localparam [2:0] S_TX     = 3'h3;
  localparam [2:0] S_TX_ACK = 3'h4;

  localparam [1:0] K_ADDR = 2'h0;
  localparam [1:0] K_PTR  = 2'h1;
  localparam [1:0] K_DATA = 2'h2;

  // Pointer lies on a clock location rather than calibration
  function is_clock_loc;
    input [2:0] a;
    begin
      is_clock_loc = (a <= `RTCSA_LAST_CLOCK);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;
  reg pf_m;
  reg pf_s;

  always @(posedge sys_clk_in) begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    sda_m <= sda_in;
    sda_s <= sda_m;
    pf_m  <= below_power_fail_threshold_in;
    pf_s  <= pf_m;
    if (!rstn_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // Line changes with SCL high are conditions, not data
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------------
  reg [2:0]  state;
  reg [1:0]  kind;
  reg [3:0]  bitcnt;
  reg [7:0]  shreg;
  reg [7:0]  txsh;
  reg [2:0]  ptr;
  reg        rw;
  reg        mack;
  reg        sda_oe;
  reg        push;
  reg [10:0] pdata;
  reg [7:0]  ucopy [0:`RTCSA_NUM_LOCS-1];

  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [10:0] buf_out_data;
  wire        tk_ready;
  wire [63:0] tk_time;
  wire [7:0]  rd_byte = ucopy[ptr];
  wire        addr_hit = (shreg[7:1] == `RTCSA_SLAVE_ADDR);

  // Open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe;
  assign busy_out   = (state != S_IDLE);

  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state  <= S_IDLE;
      kind   <= K_ADDR;
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
      txsh   <= 8'h00;
      ptr    <= 3'h0;
      rw     <= 1'b0;
      mack   <= 1'b0;
      sda_oe <= 1'b0;
      push   <= 1'b0;
      pdata  <= 11'h000;
    end else begin
      push <= 1'b0;
      if (pf_s) begin
        // Low supply beats every bus event
        state  <= S_IDLE;
        ptr    <= 3'h0;
        sda_oe <= 1'b0;
        bitcnt <= 4'h0;
      end else if (start_c) begin
        // Repeated start is legal at any point
        state  <= S_RX;
        kind   <= K_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise && bitcnt != `RTCSA_BYTE_BITS) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == `RTCSA_BYTE_BITS) begin
              if (kind == K_ADDR && !addr_hit) begin
                state <= S_IDLE;
              end else if (kind == K_DATA && !buf_in_ready) begin
                // Nowhere to put the byte: refuse it
                state <= S_IDLE;
              end else begin
                sda_oe <= 1'b1;
                state  <= S_RX_ACK;
              end
            end
          end
          S_RX_ACK: begin
            if (scl_rise) begin
              case (kind)
                K_ADDR: rw <= shreg[0];
                K_PTR: ptr <= shreg[2:0];
                default: begin
                  push  <= 1'b1;
                  pdata <= {ptr, shreg};
                  ptr   <= ptr + 3'h1;
                end
              endcase
            end else if (scl_fall) begin
              // Ack held through the high phase, dropped only now
              bitcnt <= 4'h0;
              if (kind == K_ADDR && rw) begin
                txsh   <= rd_byte;
                sda_oe <= ~rd_byte[7];
                bitcnt <= 4'h1;
                state  <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= S_RX;
                kind   <= (kind == K_ADDR) ? K_PTR : K_DATA;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == `RTCSA_BYTE_BITS) begin
                sda_oe <= 1'b0;
                state  <= S_TX_ACK;
              end else begin
                sda_oe <= ~txsh[6];
                txsh   <= {txsh[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              mack <= ~sda_s;
              ptr  <= ptr + 3'h1;
            end else if (scl_fall) begin
              if (mack) begin
                txsh   <= rd_byte;
                sda_oe <= ~rd_byte[7];
                bitcnt <= 4'h1;
                state  <= S_TX;
              end else begin
                // Line stays released for the master's stop
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // User copy of the clock
  // ----------------------------------------------------------------------
  // Frozen so a multi-byte read never sees a carry mid-block
  wire freeze = busy_out & is_clock_loc(ptr);
  integer k;

  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (k = 0; k < `RTCSA_NUM_LOCS; k = k + 1)
        ucopy[k] <= `RTCSA_RST_ZERO;
    end else if (!freeze) begin
      for (k = 0; k < `RTCSA_NUM_LOCS; k = k + 1)
        ucopy[k] <= tk_time[k*8 +: 8];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RTCSA_NUM_LOCS; g = g + 1) begin : g_out
      assign time_out[g*8 +: 8] = ucopy[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Write path and counters
  // ----------------------------------------------------------------------
  rtcsa_buf2 #(
    .W  (11),
    .AW (1)
  ) u_buf (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (pdata),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (tk_ready),
    .out_data_out  (buf_out_data)
  );

  rtcsa_timekeep #(
    .DIV_COUNT (DIV_COUNT)
  ) u_tk (
    .sys_clk_in   (sys_clk_in),
    .rstn_in      (rstn_in),
    .osc_clk_in   (osc_clk_in),
    .wr_valid_in  (buf_out_valid),
    .wr_ready_out (tk_ready),
    .wr_addr_in   (buf_out_data[10:8]),
    .wr_data_in   (buf_out_data[7:0]),
    .time_out     (tk_time)
  );

endmodule

// >>> tb/rtcsa_slave_asserts.sv
// Purpose: Port checks of the serial clock slave
// Assumes: SDA and SCL seen at the resolved wire level
// Notes: Bound to every instance of the top module
`timescale 1ns/10ps
`include "rtcsa_consts.vh"

module rtcsa_slave_asserts #(
  parameter [`RTCSA_DIV_W-1:0] DIV_COUNT = `RTCSA_DIV_COUNT
) (
  input wire        sys_clk_in,
  input wire        rstn_in,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire        osc_clk_in,
  input wire        below_power_fail_threshold_in,
  input wire        busy_out,
  input wire [63:0] time_out
);
  wire pf;
  assign pf = below_power_fail_threshold_in;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // ----
  // Bus
  // ----
  // Five cycles leave room for the two-stage sync
  AST_PF_IDLE: assert property (
    pf [*5] |-> !sda_oe_out && !busy_out)
    else $error("bus active in power fail");
  AST_PF_DEAF: assert property (
    pf && $past(pf) |-> !$rose(busy_out))
    else $error("transfer began in power fail");
  AST_OE_RISE: assert property (
    $rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda pulled while scl high");
  AST_OE_FALL: assert property (
    $fell(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda released while scl high");
  AST_START_BUSY: assert property (
    $rose(busy_out) |-> scl_in && !sda_in)
    else $error("busy without start");
  AST_STOP_IDLE: assert property (
    scl_in && $rose(sda_in) |-> ##[1:6] !busy_out)
    else $error("stop did not end transfer");
  AST_OE_ADDRESSED: assert property (
    $rose(sda_oe_out) |-> busy_out)
    else $error("sda pulled while idle");
  // ----
  // Counters
  // ----
  AST_SEC_BCD: assert property (
    time_out[3:0] <= 4'h9 && time_out[6:4] <= 3'h5)
    else $error("seconds not bcd");
  AST_HOUR_24: assert property (
    time_out[21:16] <= 6'h23)
    else $error("hour beyond 23");
  AST_MONTH: assert property (
    time_out[44:40] <= 5'h12)
    else $error("month beyond 12");
endmodule

bind rtcsa_slave rtcsa_slave_asserts #(.DIV_COUNT(DIV_COUNT)) u_chk (
  .sys_clk_in                    (sys_clk_in),
  .rstn_in                       (rstn_in),
  .scl_in                        (scl_in),
  .sda_in                        (sda_in),
  .sda_out                       (sda_out),
  .sda_oe_out                    (sda_oe_out),
  .osc_clk_in                    (osc_clk_in),
  .below_power_fail_threshold_in (below_power_fail_threshold_in),
  .busy_out                      (busy_out),
  .time_out                      (time_out)
);

// >>> tb/rtcsa_bus_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: sda_in is the wire level with pull-up
// Notes: Changes on rising edges; samples mid high phase
`timescale 1ns/10ps

module rtcsa_bus_master #(
  parameter HALF = 10
) (
  input  wire sys_clk_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task wait_clk(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge sys_clk_in);
      end
    end
  endtask
  // Data moves two cycles after SCL falls, never while high
  task bit_xfer(input b, output s);
    begin
      wait_clk(2);
      sda_pull_out <= ~b;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF / 2);
      @(negedge sys_clk_in) s = sda_in;
      wait_clk(HALF / 2);
      scl_out <= 1'b0;
    end
  endtask
  task start;
    begin
      wait_clk(2);
      sda_pull_out <= 1'b0;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      sda_pull_out <= 1'b1;
      wait_clk(HALF);
      scl_out <= 1'b0;
    end
  endtask
  task stop;
    begin
      wait_clk(2);
      sda_pull_out <= 1'b1;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      sda_pull_out <= 1'b0;
      wait_clk(HALF);
    end
  endtask
  task send_byte(input [7:0] d, output ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_xfer(d[i], s);
      end
      bit_xfer(1'b1, s);
      ack = ~s;
    end
  endtask
  // Ninth slot: pull low to ack, release on the last byte
  task recv_byte(input mack, output [7:0] d, output s9);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_xfer(1'b1, s);
        d[i] = s;
      end
      bit_xfer(~mack, s9);
    end
  endtask
endmodule

// >>> tb/tb_rtcsa_slave.sv
// Purpose: Self-checking bench of the serial clock slave
// Assumes: Bus master model drives SCL and pulls SDA
// Notes: Crystal edges given by hand so ticks are predictable
`timescale 1ns/10ps

module tb_rtcsa_slave;
  localparam LIMIT = 30000;
  localparam [7:0] ACKED = 8'h01;
  localparam [7:0] NOACK = 8'h00;
  typedef struct packed {
    logic [2:0] loc;
    logic [7:0] val;
    logic [7:0] exp;
  } rtcsa_row_t;
  reg         sys_clk;
  reg         rstn;
  reg         osc;
  reg         pf;
  wire        scl;
  wire        sda_pull;
  wire        sda_line;
  wire        sda_drv;
  wire        sda_oe;
  wire        busy;
  wire [63:0] time_val;
  integer     num_errors = 0;
  integer     cmp_count = 0;
  integer     cycles = 0;
  integer     k;
  reg  [7:0]  wbuf [0:7];
  reg  [7:0]  ebuf [0:7];
  reg  [7:0]  got;
  reg         ack;
  reg         nak;
  rtcsa_row_t rows [0:7];

  assign sda_line = (sda_oe ? sda_drv : 1'b1) & ~sda_pull;

  rtcsa_slave #(.DIV_COUNT(16'h0004)) uut (
    .sys_clk_in                    (sys_clk),
    .rstn_in                       (rstn),
    .scl_in                        (scl),
    .sda_in                        (sda_line),
    .sda_out                       (sda_drv),
    .sda_oe_out                    (sda_oe),
    .osc_clk_in                    (osc),
    .below_power_fail_threshold_in (pf),
    .busy_out                      (busy),
    .time_out                      (time_val)
  );
  rtcsa_bus_master mst (
    .sys_clk_in   (sys_clk),
    .sda_in       (sda_line),
    .scl_out      (scl),
    .sda_pull_out (sda_pull)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  // ----
  // Tasks
  // ----
  task check(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task chk_time(input [63:0] exp);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        check(time_val[8*i +: 8], exp[8*i +: 8]);
      end
    end
  endtask
  task osc_pulse;
    begin
      osc <= 1'b1;
      mst.wait_clk(20);
      osc <= 1'b0;
      mst.wait_clk(20);
    end
  endtask
  task wr_seq(input [2:0] ptr, input integer n);
    integer i;
    begin
      mst.start;
      mst.send_byte(8'hd0, ack);
      check({7'h00, ack}, ACKED);
      mst.send_byte({5'h00, ptr}, ack);
      check({7'h00, ack}, ACKED);
      for (i = 0; i < n; i = i + 1) begin
        mst.send_byte(wbuf[i], ack);
        check({7'h00, ack}, ACKED);
      end
      mst.stop;
      mst.wait_clk(20);
    end
  endtask
  task rd_seq(input integer n);
    integer i;
    begin
      mst.start;
      mst.send_byte(8'hd1, ack);
      check({7'h00, ack}, ACKED);
      for (i = 0; i < n; i = i + 1) begin
        mst.recv_byte(i < n - 1, got, nak);
        check(got, ebuf[i]);
      end
      check({7'h00, nak}, ACKED);
      mst.stop;
      mst.wait_clk(20);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    rstn = 1'b0;
    osc = 1'b0;
    pf = 1'b0;
    rows[0] = {3'h0, 8'h45, 8'h45};
    rows[1] = {3'h1, 8'h37, 8'h37};
    rows[2] = {3'h2, 8'h21, 8'h21};
    rows[3] = {3'h3, 8'h05, 8'h05};
    rows[4] = {3'h4, 8'h17, 8'h17};
    rows[5] = {3'h5, 8'h09, 8'h09};
    rows[6] = {3'h6, 8'h88, 8'h88};
    rows[7] = {3'h7, 8'h2a, 8'h2a};
    mst.wait_clk(12);
    rstn <= 1'b1;
    mst.wait_clk(4);
    chk_time(64'h0000010101000000);
    $display("test reset done");
    for (k = 0; k < 8; k = k + 1) begin
      wbuf[0] = rows[k].val;
      wr_seq(rows[k].loc, 1);
      check(time_val[{rows[k].loc, 3'h0} +: 8], rows[k].exp);
    end
    $display("test rows done");
    // Read from 6 wraps past 7 back to seconds
    wr_seq(3'h6, 0);
    ebuf[0] = 8'h88;
    ebuf[1] = 8'h2a;
    ebuf[2] = 8'h45;
    rd_seq(3);
    $display("test read wrap done");
    wbuf[0] = 8'h59;
    wbuf[1] = 8'h59;
    wbuf[2] = 8'h23;
    wbuf[3] = 8'h01;
    wbuf[4] = 8'h28;
    wbuf[5] = 8'h02;
    wbuf[6] = 8'h24;
    // Edges before the write must not count toward the tick
    osc_pulse;
    osc_pulse;
    wr_seq(3'h0, 7);
    chk_time(64'h2a24022801235959);
    for (k = 0; k < 4; k = k + 1) begin
      if (k == 3)
        chk_time(64'h2a24022801235959);
      osc_pulse;
    end
    mst.wait_clk(40);
    chk_time(64'h2a24022902000000);
    $display("test tick done");
    // Address one bit off must be ignored
    mst.start;
    mst.send_byte(8'hd2, ack);
    check({7'h00, ack}, NOACK);
    mst.send_byte(8'h00, ack);
    check({6'h00, ack, busy}, NOACK);
    mst.stop;
    $display("test wrong address done");
    mst.start;
    mst.send_byte(8'hd0, ack);
    mst.send_byte(8'h05, ack);
    mst.wait_clk(8);
    pf <= 1'b1;
    mst.wait_clk(8);
    check({5'h00, sda_drv, busy, sda_oe}, NOACK);
    mst.send_byte(8'h11, ack);
    check({7'h00, ack}, NOACK);
    mst.stop;
    mst.start;
    mst.send_byte(8'hd0, ack);
    check({6'h00, ack, busy}, NOACK);
    mst.stop;
    pf <= 1'b0;
    mst.wait_clk(10);
    check(time_val[47:40], wbuf[5]);
    ebuf[0] = 8'h00;
    rd_seq(1);
    $display("test power fail done");
    conclude;
  end
endmodule
